// [pkg/sah_pkg.sv]
// Package: register map, field layout and reset values of the address and hash registers
package sah_pkg;
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFS_STA_LOW     = 8'hA4;
  localparam logic [7:0]  OFS_STA_HIGH    = 8'hA8;
  localparam logic [7:0]  OFS_HASH_LOW    = 8'hAC;
  localparam logic [7:0]  OFS_HASH_HIGH   = 8'hB0;
  localparam logic [2:0]  RX_STOPPED      = 3'h0;
  localparam logic [47:0] STA_RESET       = 48'h000000000000;
  localparam logic [31:0] HASH_RESET      = 32'h00000000;
  localparam logic [15:0] RSVD_ZERO       = 16'h0000;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  typedef enum {SEL_NONE, SEL_STA_LOW, SEL_STA_HIGH, SEL_HASH_LOW, SEL_HASH_HIGH} sah_sel_t;
endpackage

// [pkg/sah_reg_if.sv]
// Interface: register access strobes between the bus slave and the register bank
`timescale 1ns/100ps
interface sah_reg_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic        rd_en;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_ok, rd_data, rd_ok);
  modport bank  (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface // sah_reg_if

// [verilog/sah_axil_slave.sv]
// AXI4-Lite slave turning bus transfers into single-cycle register strobes
`timescale 1ns/100ps
module sah_axil_slave (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  sah_reg_if.slave         regs
);
  logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt, ar_hold_r, ar_hold_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt, araddr_r, araddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic        awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic        fire_wr, fire_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Address and data latch independently; one write and one read in flight
  assign fire_wr = aw_hold_r && w_hold_r && !bvalid_r;
  assign fire_rd = ar_hold_r && !rvalid_r;

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    ar_hold_nxt = ar_hold_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    araddr_nxt  = araddr_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (awvalid && awready_r) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt  = awaddr;
    end
    if (wvalid && wready_r) begin
      w_hold_nxt = 1'b1;
      wdata_nxt  = wdata;
      wstrb_nxt  = wstrb;
    end
    if (arvalid && arready_r) begin
      ar_hold_nxt = 1'b1;
      araddr_nxt  = araddr;
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (fire_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = regs.wr_ok ? sah_pkg::RESP_OKAY : sah_pkg::RESP_SLVERR;
    end
    if (fire_rd) begin
      ar_hold_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rdata_nxt   = regs.rd_data;
      rresp_nxt   = regs.rd_ok ? sah_pkg::RESP_OKAY : sah_pkg::RESP_SLVERR;
    end
    // Ready drops while a latched item or an answer is pending
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt  = !w_hold_nxt && !bvalid_nxt;
    arready_nxt = !ar_hold_nxt && !rvalid_nxt;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      ar_hold_r <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      araddr_r  <= 8'h00;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      rvalid_r  <= 1'b0;
      rresp_r   <= 2'h0;
      rdata_r   <= 32'h00000000;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      arready_r <= 1'b0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      ar_hold_r <= ar_hold_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      araddr_r  <= araddr_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  assign regs.wr_en   = fire_wr;
  assign regs.wr_addr = awaddr_r;
  assign regs.wr_data = wdata_r;
  assign regs.wr_strb = wstrb_r;
  assign regs.rd_en   = fire_rd;
  assign regs.rd_addr = araddr_r;
  assign awready      = awready_r;
  assign wready       = wready_r;
  assign arready      = arready_r;
  assign bvalid       = bvalid_r;
  assign bresp        = bresp_r;
  assign rvalid       = rvalid_r;
  assign rresp        = rresp_r;
  assign rdata        = rdata_r;
endmodule // sah_axil_slave

// [verilog/sah_regs.sv]
// Station address and multicast hash register bank behind an AXI4-Lite port
// How it works
// - Station byte zero sits in bits 7..0 of the low station register and is read/write.
// - The high station register holds byte five in bits 15..8 and byte four in bits 7..0, upper bits reserved.
// - After reset the station bytes are zero (STA_RESET); the EEPROM contents are loaded only when eeprom_load is asserted.
// - Both station registers always read back, but writes take effect only while the receive state is 000.
// - The first octet on the wire is the lowest byte of the low register, later octets climb the byte lanes.
// - The low hash register holds hash bits 31..0 byte by byte, read/write, reset to zero.
// - The high hash register holds hash bits 63..56 in its top byte, read/write, reset to zero.
// - The low station register sits at a4h with bytes three, two and one in bits 31..8, loaded from EEPROM.
`timescale 1ns/100ps
module sah_regs #(
  parameter int ADDR_W = sah_pkg::ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [2:0]        rx_state,
  input  wire logic              eeprom_load,
  input  wire logic [47:0]       eeprom_station,
  output logic [47:0]            station_addr,
  output logic [63:0]            hash_table
);
  if (ADDR_W != 8) begin : g_bad_width
    $error("sah_regs: ADDR_W must be 8");
  end

  sah_reg_if regs ();

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [47:0] sta_r, sta_nxt;
  logic [31:0] hash_lo_r, hash_lo_nxt, hash_hi_r, hash_hi_nxt;
  logic        stopped;
  logic [31:0] sta_hi_word;
  sah_pkg::sah_sel_t wsel, rsel;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  sah_axil_slave u_slave (
    .clk     (clk),
    .reset   (reset),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .regs    (regs)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode, shared by read and write
  function automatic sah_pkg::sah_sel_t decode(input logic [7:0] a);
    if (a == sah_pkg::OFS_STA_LOW) begin
      decode = sah_pkg::SEL_STA_LOW;
    end else if (a == sah_pkg::OFS_STA_HIGH) begin
      decode = sah_pkg::SEL_STA_HIGH;
    end else if (a == sah_pkg::OFS_HASH_LOW) begin
      decode = sah_pkg::SEL_HASH_LOW;
    end else if (a == sah_pkg::OFS_HASH_HIGH) begin
      decode = sah_pkg::SEL_HASH_HIGH;
    end else begin
      decode = sah_pkg::SEL_NONE;
    end
  endfunction

  // Byte-lane merge under write strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  assign wsel    = decode(regs.wr_addr);
  assign rsel    = decode(regs.rd_addr);
  assign stopped = (rx_state == sah_pkg::RX_STOPPED);
  // Reserved lanes start from zero before the merge; only the low half is kept
  assign sta_hi_word = merge({sah_pkg::RSVD_ZERO, sta_r[47:32]}, regs.wr_data, regs.wr_strb);

  ////////////////////////////////////////////////////////////////////////////
  // Register next state
  always_comb begin
    sta_nxt     = sta_r;
    hash_lo_nxt = hash_lo_r;
    hash_hi_nxt = hash_hi_r;
    regs.wr_ok  = (wsel != sah_pkg::SEL_NONE);
    if (regs.wr_en) begin
      case (wsel)
        sah_pkg::SEL_STA_LOW: begin
          // Locked while receive runs so the filter never sees a half-written address
          if (stopped) begin
            sta_nxt[31:0] = merge(sta_r[31:0], regs.wr_data, regs.wr_strb);
          end
        end
        sah_pkg::SEL_STA_HIGH: begin
          if (stopped) begin
            sta_nxt[47:32] = sta_hi_word[15:0];
          end
        end
        sah_pkg::SEL_HASH_LOW: begin
          hash_lo_nxt = merge(hash_lo_r, regs.wr_data, regs.wr_strb);
        end
        sah_pkg::SEL_HASH_HIGH: begin
          hash_hi_nxt = merge(hash_hi_r, regs.wr_data, regs.wr_strb);
        end
        default: begin
        end
      endcase
    end
    // EEPROM recall wins over a software write in the same cycle
    if (eeprom_load) begin
      sta_nxt = eeprom_station;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sta_r     <= sah_pkg::STA_RESET;
      hash_lo_r <= sah_pkg::HASH_RESET;
      hash_hi_r <= sah_pkg::HASH_RESET;
    end else begin
      sta_r     <= sta_nxt;
      hash_lo_r <= hash_lo_nxt;
      hash_hi_r <= hash_hi_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; station registers readable in every receive state
  always_comb begin
    regs.rd_ok   = (rsel != sah_pkg::SEL_NONE);
    regs.rd_data = 32'h00000000;
    case (rsel)
      sah_pkg::SEL_STA_LOW:   regs.rd_data = sta_r[31:0];
      sah_pkg::SEL_STA_HIGH:  regs.rd_data = {sah_pkg::RSVD_ZERO, sta_r[47:32]};
      sah_pkg::SEL_HASH_LOW:  regs.rd_data = hash_lo_r;
      sah_pkg::SEL_HASH_HIGH: regs.rd_data = hash_hi_r;
      default: begin
      end
    endcase
  end

  assign station_addr = sta_r;
  assign hash_table   = {hash_hi_r, hash_lo_r};

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_station_locked: assert property (
    regs.wr_en && (wsel == sah_pkg::SEL_STA_LOW || wsel == sah_pkg::SEL_STA_HIGH) && !stopped && !eeprom_load
      |=> station_addr == $past(station_addr))
    else $error("station address changed while receive running");
  a_locked_okay: assert property (
    regs.wr_en && wsel == sah_pkg::SEL_STA_LOW && !stopped |=> s_axi_bvalid && s_axi_bresp == sah_pkg::RESP_OKAY)
    else $error("locked station write not answered okay");
  a_low_write: assert property (
    regs.wr_en && wsel == sah_pkg::SEL_STA_LOW && stopped && regs.wr_strb == 4'hF && !eeprom_load
      |=> station_addr[31:0] == $past(regs.wr_data))
    else $error("low station write lost");
  a_high_write: assert property (
    regs.wr_en && wsel == sah_pkg::SEL_STA_HIGH && stopped && regs.wr_strb == 4'hF && !eeprom_load
      |=> station_addr[47:32] == $past(regs.wr_data[15:0]))
    else $error("high station write lost");
  a_eeprom_recall: assert property (
    eeprom_load |=> station_addr == $past(eeprom_station))
    else $error("eeprom recall not stored");
  a_octet_order: assert property (
    regs.rd_en && rsel == sah_pkg::SEL_STA_LOW |=> s_axi_rdata[7:0] == $past(station_addr[7:0]))
    else $error("first octet not in lowest lane");
  a_high_reserved: assert property (
    regs.rd_en && rsel == sah_pkg::SEL_STA_HIGH |=> s_axi_rdata[31:16] == sah_pkg::RSVD_ZERO)
    else $error("reserved station bits not zero");
  a_hash_low: assert property (
    regs.wr_en && wsel == sah_pkg::SEL_HASH_LOW && regs.wr_strb == 4'hF |=> hash_table[31:0] == $past(regs.wr_data))
    else $error("hash low write lost");
  a_hash_top: assert property (
    regs.wr_en && wsel == sah_pkg::SEL_HASH_HIGH && regs.wr_strb[3] |=> hash_table[63:56] == $past(regs.wr_data[31:24]))
    else $error("hash top byte write lost");
  a_hash_reset: assert property (
    $past(reset) |-> hash_table == {sah_pkg::HASH_RESET, sah_pkg::HASH_RESET})
    else $error("hash table not zero after reset");
  a_low_offset: assert property (
    regs.rd_en && regs.rd_addr == sah_pkg::OFS_STA_LOW |=> s_axi_rvalid && s_axi_rdata == $past(station_addr[31:0]))
    else $error("low station register not at its offset");
  a_high_locked_okay: assert property (
    regs.wr_en && wsel == sah_pkg::SEL_STA_HIGH && !stopped |=> s_axi_bvalid && s_axi_bresp == sah_pkg::RESP_OKAY)
    else $error("locked high station write not answered okay");
  a_station_readable: assert property (
    regs.rd_en && (rsel == sah_pkg::SEL_STA_LOW || rsel == sah_pkg::SEL_STA_HIGH)
      |=> s_axi_rvalid && s_axi_rresp == sah_pkg::RESP_OKAY)
    else $error("station register read refused");
  a_high_readback: assert property (
    regs.rd_en && rsel == sah_pkg::SEL_STA_HIGH |=> s_axi_rdata[15:0] == $past(station_addr[47:32]))
    else $error("high station bytes not read back");
  a_hash_kept: assert property (
    regs.wr_en && (wsel == sah_pkg::SEL_STA_LOW || wsel == sah_pkg::SEL_STA_HIGH) |=> hash_table == $past(hash_table))
    else $error("station write disturbed hash table");
  a_station_kept: assert property (
    regs.wr_en && (wsel == sah_pkg::SEL_HASH_LOW || wsel == sah_pkg::SEL_HASH_HIGH) && !eeprom_load
      |=> station_addr == $past(station_addr))
    else $error("hash write disturbed station address");
  a_hash_lane_kept: assert property (
    regs.wr_en && wsel == sah_pkg::SEL_HASH_LOW && !regs.wr_strb[1] |=> hash_table[15:8] == $past(hash_table[15:8]))
    else $error("hash byte written without its strobe");
endmodule // sah_regs

// [tb/tb.sv]
// Testbench: station address and multicast hash registers over AXI4-Lite
`timescale 1ns/100ps
module tb;
  logic        clk;
  logic        reset;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [2:0]  rx_state;
  logic        eeprom_load;
  logic [47:0] eeprom_station;
  logic [47:0] station_addr;
  logic [63:0] hash_table;
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          fails;
  int          cmp_count;

  sah_regs dut_u (
    .clk(clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_state(rx_state), .eeprom_load(eeprom_load), .eeprom_station(eeprom_station),
    .station_addr(station_addr), .hash_table(hash_table)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Bounded waits only; a hung handshake ends the run
  task automatic bus_hang(input string what);
    fails++;
    $display("wrong value %s: expected handshake, seen none", what);
    report_and_stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] resp);
    int   n;
    logic aw_open;
    logic w_open;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_open = 1'b1;
    w_open  = 1'b1;
    resp    = 2'h3;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (aw_open && awready) begin
        awvalid <= 1'b0;
        aw_open = 1'b0;
      end
      if (w_open && wready) begin
        wvalid <= 1'b0;
        w_open = 1'b0;
      end
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 40) bus_hang("write response");
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int   n;
    logic ar_open;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    ar_open = 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (ar_open && arready) begin
        arvalid <= 1'b0;
        ar_open = 1'b0;
      end
      if (rvalid === 1'b1) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 40) bus_hang("read data");
  endtask

  task automatic read_check(input string what, input logic [7:0] a, input logic [31:0] exp,
                            input logic [1:0] exp_resp);
    axi_read(a, rd, rsp);
    check(what, rd, exp);
    check({what, " resp"}, rsp, exp_resp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    read_check("hash low", sah_pkg::OFS_HASH_LOW, 32'h00000000, sah_pkg::RESP_OKAY);
    read_check("hash high", sah_pkg::OFS_HASH_HIGH, 32'h00000000, sah_pkg::RESP_OKAY);
    check("hash out", hash_table, 64'h0000000000000000);
    $display("test reset_values done");
  endtask

  // Octet order on the wire 00-00-E8-11-22-33
  task automatic t_eeprom_load;
    @(posedge clk);
    eeprom_station <= 48'h332211E80000;
    eeprom_load    <= 1'b1;
    @(posedge clk);
    eeprom_load    <= 1'b0;
    eeprom_station <= 48'hFFFFFFFFFFFF;
    @(posedge clk);
    check("station out", station_addr, 64'h0000332211E80000);
    read_check("station low", sah_pkg::OFS_STA_LOW, 32'h11E80000, sah_pkg::RESP_OKAY);
    read_check("station high", sah_pkg::OFS_STA_HIGH, 32'h00003322, sah_pkg::RESP_OKAY);
    $display("test eeprom_load done");
  endtask

  task automatic t_station_write;
    axi_write(sah_pkg::OFS_STA_LOW, 32'hA1B2C3D4, 4'hF, rsp);
    check("station low wr resp", rsp, sah_pkg::RESP_OKAY);
    axi_write(sah_pkg::OFS_STA_HIGH, 32'hDEADBEEF, 4'hF, rsp);
    read_check("station low", sah_pkg::OFS_STA_LOW, 32'hA1B2C3D4, sah_pkg::RESP_OKAY);
    read_check("station high", sah_pkg::OFS_STA_HIGH, 32'h0000BEEF, sah_pkg::RESP_OKAY);
    check("station out", station_addr, 64'h0000BEEFA1B2C3D4);
    $display("test station_write done");
  endtask

  // Every running receive state must lock the station registers
  task automatic t_station_locked;
    for (int st = 1; st < 8; st++) begin
      rx_state <= 3'(st);
      axi_write(sah_pkg::OFS_STA_LOW, 32'h55555555, 4'hF, rsp);
      check("locked low resp", rsp, sah_pkg::RESP_OKAY);
      axi_write(sah_pkg::OFS_STA_HIGH, 32'h66666666, 4'hF, rsp);
      check("locked high resp", rsp, sah_pkg::RESP_OKAY);
      read_check("locked low", sah_pkg::OFS_STA_LOW, 32'hA1B2C3D4, sah_pkg::RESP_OKAY);
      check("locked out", station_addr, 64'h0000BEEFA1B2C3D4);
    end
    rx_state <= sah_pkg::RX_STOPPED;
    $display("test station_locked done");
  endtask

  task automatic t_hash_bytes;
    axi_write(sah_pkg::OFS_HASH_LOW, 32'hFFFFFFFF, 4'hF, rsp);
    axi_write(sah_pkg::OFS_HASH_LOW, 32'h12345678, 4'h5, rsp);
    read_check("hash low", sah_pkg::OFS_HASH_LOW, 32'hFF34FF78, sah_pkg::RESP_OKAY);
    axi_write(sah_pkg::OFS_HASH_HIGH, 32'hA5C35A3C, 4'hF, rsp);
    read_check("hash high", sah_pkg::OFS_HASH_HIGH, 32'hA5C35A3C, sah_pkg::RESP_OKAY);
    check("hash out", hash_table, 64'hA5C35A3CFF34FF78);
    $display("test hash_bytes done");
  endtask

  task automatic t_unmapped;
    axi_write(8'hB4, 32'h0BADF00D, 4'hF, rsp);
    check("unmapped wr resp", rsp, sah_pkg::RESP_SLVERR);
    read_check("unmapped rd", 8'hB4, 32'h00000000, sah_pkg::RESP_SLVERR);
    check("hash kept", hash_table, 64'hA5C35A3CFF34FF78);
    $display("test unmapped done");
  endtask

  // Reset in mid-run must clear a non-zero hash table
  task automatic t_mid_reset;
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("hash after reset", hash_table, 64'h0000000000000000);
    read_check("hash low rst", sah_pkg::OFS_HASH_LOW, 32'h00000000, sah_pkg::RESP_OKAY);
    read_check("hash high rst", sah_pkg::OFS_HASH_HIGH, 32'h00000000, sah_pkg::RESP_OKAY);
    $display("test mid_reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    fails = 0;
    cmp_count = 0;
    reset = 1'b1;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    rx_state = sah_pkg::RX_STOPPED;
    eeprom_load = 1'b0;
    eeprom_station = 48'h000000000000;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset_values();
    t_eeprom_load();
    t_station_write();
    t_station_locked();
    t_hash_bytes();
    t_unmapped();
    t_mid_reset();
    report_and_stop();
  end
endmodule // tb
